// ### rtl/bcw_decoder.sv
// Purpose: Decode block control words and steer the row writes of each block.
// Assumes: All inputs come from logic on mclk; no synchronisers needed.
// Notes:   Words on channels 1 to 3 are drained and dropped.
`timescale 1ns/10ps
module bcw_decoder
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [bcw_pkg::CW_W-1:0] control_word_bus,
    input wire logic cw0_valid,
    output logic cw0_ready,
    input wire logic [2:0] cw_other_valid,
    output logic [2:0] cw_other_ready,
    input wire logic [bcw_pkg::LANES-1:0] lane_valid,
    input wire logic [bcw_pkg::LANES*bcw_pkg::LANE_W-1:0] lane_data,
    output logic [bcw_pkg::LANES-1:0] lane_ready,
    output bcw_pkg::bcw_row_t row_out,
    output bcw_pkg::bcw_fields_t fields_out,
    output logic block_busy,
    input wire bcw_pkg::bcw_bus_t bus,
    output logic [31:0] rdata
);
    import bcw_pkg::*;

    // ************************************************************
    // Word decode
    // ************************************************************
    bcw_state_t state;
    bcw_state_t next_state;
    bcw_fields_t fields;
    bcw_fields_t next_fields;
    logic [IDX_W-1:0] w_idx;
    logic [OP_W-1:0] w_op;
    logic [ROWS_W-1:0] w_rows;
    logic w_single;
    logic op_ok;
    logic rows_ok;
    logic word_ok;
    logic cw_take;
    logic cw_accept;
    logic cw_discard;
    logic enable;
    logic abort;
    logic [7:0] row_addr;
    logic [ROWS_W-1:0] rows_left;
    logic beat;
    logic fill_step;
    logic last_row;
    logic [LANES-1:0] need_mask;
    logic [LANES-1:0] seg_mask;
    logic [15:0] accept_cnt;
    logic [15:0] discard_cnt;
    logic row_we;
    logic [7:0] row_wr_addr;
    logic [LANES-1:0] row_mask;
    logic [LANES*LANE_W-1:0] row_data;

    // Only named fields are sliced; reserved bits are never looked at
    assign w_idx = control_word_bus[IDX_LSB +: IDX_W];
    assign w_op = control_word_bus[OP_LSB +: OP_W];
    assign w_rows = control_word_bus[ROWS_LSB +: ROWS_W];
    assign w_single = control_word_bus[SINGLE_BIT];
    assign op_ok = (w_op == OP_LOAD) || (w_op == OP_CLEAR) || (w_op == OP_SET);
    // Row range only matters for a load
    assign rows_ok = (w_op != OP_LOAD) ||
                     ((w_rows >= ROWS_MIN) && (w_rows <= ROWS_PER_BLOCK));
    // Bad index, reserved code or out of range rows: drop the word whole
    assign word_ok = (w_idx == IDX_OK) && op_ok && rows_ok;
    assign cw_take = cw0_valid && cw0_ready;
    assign cw_accept = cw_take && word_ok;
    assign cw_discard = cw_take && !word_ok;

    // Words are taken only between blocks, so fields cannot change mid block
    assign cw0_ready = enable && (state == ST_IDLE);
    // Other channels are drained so their senders never hang
    assign cw_other_ready = 3'h7;

    always_comb
    begin
        next_fields.block = control_word_bus[BLK_LSB +: BLK_W];
        next_fields.op = w_op;
        next_fields.single = w_single;
        if (w_op == OP_LOAD)
        begin
            next_fields.rows = w_rows;
            next_fields.reverse = control_word_bus[REV_BIT];
        end
        else
        begin
            next_fields.rows = ROWS_PER_BLOCK;
            next_fields.reverse = 1'b0;
        end
        if (w_single)
        begin
            next_fields.segment = control_word_bus[SEG_LSB +: SEG_W];
        end
        else
        begin
            next_fields.segment = '0;
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            fields <= '0;
        end
        else if (cw_accept)
        begin
            fields <= next_fields;
        end
    end

    // ************************************************************
    // Block sequencing
    // ************************************************************
    // Single channel needs lane 0 only; normal mode needs all four at once
    assign need_mask = fields.single ? MASK_LANE0 : MASK_ALL;
    assign beat = (state == ST_LOAD) && (&(lane_valid | ~need_mask));
    assign lane_ready = beat ? need_mask : '0;
    assign fill_step = (state == ST_FILL);
    assign last_row = (rows_left == ROWS_MIN);
    assign seg_mask = fields.single ? (MASK_LANE0 << fields.segment) : MASK_ALL;

    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (cw_accept)
                begin
                    if (w_op == OP_LOAD)
                    begin
                        next_state = ST_LOAD;
                    end
                    else
                    begin
                        next_state = ST_FILL;
                    end
                end
            end
            ST_LOAD:
            begin
                if (abort || (beat && last_row))
                begin
                    next_state = ST_IDLE;
                end
            end
            ST_FILL:
            begin
                if (abort || last_row)
                begin
                    next_state = ST_IDLE;
                end
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= ST_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // Row pointer and rows still to write
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            row_addr <= ROW_FIRST;
            rows_left <= '0;
        end
        else if (cw_accept)
        begin
            rows_left <= next_fields.rows;
            if (next_fields.reverse)
            begin
                row_addr <= ROW_LAST;
            end
            else
            begin
                row_addr <= ROW_FIRST;
            end
        end
        else if (beat || fill_step)
        begin
            rows_left <= rows_left - ROWS_MIN;
            if (fields.reverse)
            begin
                row_addr <= row_addr - 8'h01;
            end
            else
            begin
                row_addr <= row_addr + 8'h01;
            end
        end
    end

    // ************************************************************
    // Row output
    // ************************************************************
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            row_we <= 1'b0;
            row_wr_addr <= '0;
            row_mask <= '0;
        end
        else
        begin
            row_we <= beat || fill_step;
            row_wr_addr <= row_addr;
            row_mask <= seg_mask;
        end
    end

    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : g_lane
            always_ff @(posedge mclk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    row_data[g*LANE_W +: LANE_W] <= '0;
                end
                else if (fill_step)
                begin
                    // Clear gives zeros, set gives ones across the row
                    row_data[g*LANE_W +: LANE_W] <= {LANE_W{fields.op == OP_SET}};
                end
                else if (beat)
                begin
                    // Single channel copies lane 0 into every slot; the lane mask marks its segment
                    if (fields.single)
                    begin
                        row_data[g*LANE_W +: LANE_W] <= lane_data[0 +: LANE_W];
                    end
                    else
                    begin
                        row_data[g*LANE_W +: LANE_W] <= lane_data[g*LANE_W +: LANE_W];
                    end
                end
            end
        end
    endgenerate

    assign fields_out = fields;
    assign row_out = '{row_we, row_wr_addr, row_mask, row_data};
    assign block_busy = (state != ST_IDLE);

    // ************************************************************
    // Register port
    // ************************************************************
    assign abort = bus.wr && (bus.addr == REG_CTRL) && bus.wdata[CTRL_ABORT_BIT];

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            enable <= CTRL_ENABLE_RST;
        end
        else if (bus.wr && (bus.addr == REG_CTRL))
        begin
            enable <= bus.wdata[CTRL_ENABLE_BIT];
        end
    end

    // A write clears a counter; an event in the same cycle still counts
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            accept_cnt <= '0;
        end
        else if (bus.wr && (bus.addr == REG_ACCEPT))
        begin
            accept_cnt <= cw_accept ? CNT_ONE : '0;
        end
        else if (cw_accept)
        begin
            accept_cnt <= accept_cnt + CNT_ONE;
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            discard_cnt <= '0;
        end
        else if (bus.wr && (bus.addr == REG_DISCARD))
        begin
            discard_cnt <= cw_discard ? CNT_ONE : '0;
        end
        else if (cw_discard)
        begin
            discard_cnt <= discard_cnt + CNT_ONE;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata <= '0;
        end
        else if (bus.rd)
        begin
            case (bus.addr)
                REG_CTRL: rdata <= {31'h0, enable};
                REG_STATUS: rdata <= {13'h0, rows_left, row_addr, state};
                REG_FIELDS: rdata <= {12'h0, fields};
                REG_ACCEPT: rdata <= {16'h0, accept_cnt};
                REG_DISCARD: rdata <= {16'h0, discard_cnt};
                default: rdata <= '0;
            endcase
        end
        else
        begin
            rdata <= '0;
        end
    end
endmodule

// ### rtl/bcw_pkg.sv
// Purpose: Shared constants and types for the block control word decoder.
// Assumes: Control word and block data arrive on the mclk domain.
// Notes:   Register offsets are byte addresses on the plain register port.
package bcw_pkg;
    // ************************************************************
    // Control word layout
    // ************************************************************
    localparam int CW_W = 192;
    localparam int IDX_LSB = 0;
    localparam int IDX_W = 8;
    localparam int BLK_LSB = 8;
    localparam int BLK_W = 4;
    localparam int ROWS_LSB = 16;
    localparam int ROWS_W = 9;
    localparam int SEG_LSB = 28;
    localparam int SEG_W = 2;
    localparam int SINGLE_BIT = 30;
    localparam int OP_LSB = 32;
    localparam int OP_W = 3;
    localparam int REV_BIT = 36;
    localparam logic [IDX_W-1:0] IDX_OK = 8'h00;
    localparam logic [ROWS_W-1:0] ROWS_PER_BLOCK = 9'h088;
    localparam logic [ROWS_W-1:0] ROWS_MIN = 9'h001;
    localparam logic [OP_W-1:0] OP_LOAD = 3'h0;
    localparam logic [OP_W-1:0] OP_CLEAR = 3'h1;
    localparam logic [OP_W-1:0] OP_SET = 3'h2;
    localparam logic [7:0] ROW_FIRST = 8'h01;
    localparam logic [7:0] ROW_LAST = 8'h88;
    // ************************************************************
    // Block data lanes
    // ************************************************************
    localparam int LANES = 4;
    localparam int LANE_W = 64;
    localparam logic [LANES-1:0] MASK_ALL = 4'hf;
    localparam logic [LANES-1:0] MASK_LANE0 = 4'h1;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_FIELDS = 8'h08;
    localparam logic [ADDR_W-1:0] REG_ACCEPT = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_DISCARD = 8'h10;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_ABORT_BIT = 1;
    localparam logic CTRL_ENABLE_RST = 1'b1;
    localparam logic [15:0] CNT_ONE = 16'h0001;

    typedef struct packed {
        logic [BLK_W-1:0] block;
        logic [ROWS_W-1:0] rows;
        logic [OP_W-1:0] op;
        logic reverse;
        logic [SEG_W-1:0] segment;
        logic single;
    } bcw_fields_t;

    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [LANES-1:0] lane_mask;
        logic [LANES*LANE_W-1:0] data;
    } bcw_row_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bcw_bus_t;

    typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_FILL} bcw_state_t;
endpackage

// ### tb/bcw_decoder_chk_asserts.sv
// Purpose: Port checks for the block control word decoder.
// Assumes: Single mclk domain.
// Notes:   Fill start window allows some pipeline slack.
`timescale 1ns/10ps
module bcw_decoder_chk
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [bcw_pkg::CW_W-1:0] control_word_bus,
    input wire logic cw0_valid,
    input wire logic cw0_ready,
    input wire logic [2:0] cw_other_valid,
    input wire logic [2:0] cw_other_ready,
    input wire logic [bcw_pkg::LANES-1:0] lane_valid,
    input wire logic [bcw_pkg::LANES*bcw_pkg::LANE_W-1:0] lane_data,
    input wire logic [bcw_pkg::LANES-1:0] lane_ready,
    input wire bcw_pkg::bcw_row_t row_out,
    input wire bcw_pkg::bcw_fields_t fields_out,
    input wire logic block_busy,
    input wire bcw_pkg::bcw_bus_t bus,
    input wire logic [31:0] rdata
);
    import bcw_pkg::*;
    // ****
    // Properties
    // ****
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    logic hs;
    logic acc;
    logic [2:0] op;
    assign hs = cw0_valid && cw0_ready;
    assign acc = hs && control_word_bus[7:0] == IDX_OK;
    assign op = control_word_bus[34:32];
    property p_bad_idx;
        hs && control_word_bus[7:0] != IDX_OK |=> !block_busy;
    endproperty
    a_bad_idx: assert property (p_bad_idx) else $error("bad index started a block");
    property p_clr_f;
        acc && op == OP_CLEAR |=> fields_out.block == $past(control_word_bus[11:8])
            && fields_out.rows == ROWS_PER_BLOCK && !fields_out.reverse;
    endproperty
    a_clr_f: assert property (p_clr_f) else $error("clear fields wrong");
    property p_hold;
        block_busy && $past(block_busy) |-> $stable(fields_out);
    endproperty
    a_hold: assert property (p_hold) else $error("fields moved in block");
    property p_drop;
        cw_other_valid != 3'h0 && !cw0_valid && !block_busy |=> !block_busy;
    endproperty
    a_drop: assert property (p_drop) else $error("side channel word used");
    property p_clear;
        acc && op == OP_CLEAR |-> ##[1:3] (row_out.we && row_out.addr == ROW_FIRST
            && row_out.data == '0);
    endproperty
    a_clear: assert property (p_clear) else $error("clear fill missing");
    property p_set;
        acc && op == OP_SET |-> ##[1:3] (row_out.we && row_out.addr == ROW_FIRST
            && row_out.data == '1);
    endproperty
    a_set: assert property (p_set) else $error("set fill missing");
    property p_single;
        block_busy && fields_out.single |-> lane_ready[3:1] == 3'h0;
    endproperty
    a_single: assert property (p_single) else $error("extra lane ready");
    property p_mask;
        row_out.we && fields_out.op == OP_LOAD |-> row_out.lane_mask ==
            (fields_out.single ? 4'h1 << fields_out.segment : MASK_ALL);
    endproperty
    a_mask: assert property (p_mask) else $error("lane mask wrong");
    property p_beat;
        lane_ready != 4'h0 |=> row_out.we;
    endproperty
    a_beat: assert property (p_beat) else $error("beat wrote no row");
    property p_route;
        lane_ready != 4'h0 |=> row_out.data == (fields_out.single
            ? {4{$past(lane_data[63:0])}} : $past(lane_data));
    endproperty
    a_route: assert property (p_route) else $error("lane data routed wrong");
    property p_rd;
        !bus.rd |=> rdata == 32'h0;
    endproperty
    a_rd: assert property (p_rd) else $error("read data outside read");
    c_clear: cover property (acc && op == OP_CLEAR);
    c_set: cover property (acc && op == OP_SET);
    c_rev: cover property (acc && op == OP_LOAD && control_word_bus[36]);
endmodule
bind bcw_decoder bcw_decoder_chk bcw_decoder_chk_inst (.mclk(mclk), .arst_n(arst_n),
    .control_word_bus(control_word_bus), .cw0_valid(cw0_valid), .cw0_ready(cw0_ready),
    .cw_other_valid(cw_other_valid), .cw_other_ready(cw_other_ready),
    .lane_valid(lane_valid), .lane_data(lane_data), .lane_ready(lane_ready),
    .row_out(row_out), .fields_out(fields_out), .block_busy(block_busy),
    .bus(bus), .rdata(rdata));

// ### tb/bcw_partner.sv
// Purpose: Sender logic model for control words and lane data.
// Assumes: go pulses only while no word is pending.
// Notes:   Released or idle lines show changing junk, never old data.
`timescale 1ns/10ps
module bcw_partner
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic go,
    input wire logic [191:0] word,
    input wire logic stall,
    input wire logic cw0_ready,
    input wire logic [3:0] lane_ready,
    output logic [191:0] control_word_bus,
    output logic cw0_valid,
    output logic [3:0] lane_valid,
    output logic [255:0] lane_data
);
    import bcw_pkg::*;
    logic [31:0] pat;
    // ****
    // Word and lane drivers
    // ****
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cw0_valid <= 1'b0;
            control_word_bus <= '0;
        end
        else if (cw0_valid && cw0_ready)
        begin
            cw0_valid <= 1'b0;
            control_word_bus <= ~control_word_bus;
        end
        else if (go)
        begin
            cw0_valid <= 1'b1;
            control_word_bus <= word;
        end
    end
    // Valid only drops after a beat, so no offered row is withdrawn
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lane_valid <= 4'h0;
            pat <= 32'h1;
            lane_data <= '0;
        end
        else if (lane_ready != 4'h0 || lane_valid == 4'h0)
        begin
            lane_valid <= stall ? 4'h0 : MASK_ALL;
            pat <= pat * 32'h0019660d + 32'h3c6ef35f;
            lane_data <= {8{pat}};
        end
    end
endmodule

// ### tb/block_control_word_decoder_tb_top.sv
// Purpose: Random and corner block words through the decoder.
// Assumes: Design contract as handed over; one clock.
// Notes:   Load row data content is not compared, only order and count.
`timescale 1ns/10ps
module block_control_word_decoder_tb_top;
    import bcw_pkg::*;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic go = 1'b0;
    logic stall = 1'b0;
    logic [CW_W-1:0] word = '0;
    logic [CW_W-1:0] cwb;
    logic cwv;
    logic cwr;
    logic [2:0] ov = 3'h0;
    logic [2:0] ordy;
    logic [3:0] lv;
    logic [3:0] lr;
    logic [255:0] ld;
    bcw_row_t row;
    bcw_fields_t fo;
    bcw_fields_t last_f = '0;
    logic busy;
    bcw_bus_t bus = '0;
    logic [31:0] rdata;
    logic [31:0] seed = 32'h8b961e2f;
    logic [31:0] sreg = 32'h8b961e2f;
    int failures = 0;
    int num_checks = 0;
    int n_acc = 0;
    int n_dis = 0;
    always #50 mclk = ~mclk;
    bcw_decoder bcw_decoder_inst (.mclk(mclk), .arst_n(arst_n), .control_word_bus(cwb),
        .cw0_valid(cwv), .cw0_ready(cwr), .cw_other_valid(ov), .cw_other_ready(ordy),
        .lane_valid(lv), .lane_data(ld), .lane_ready(lr), .row_out(row),
        .fields_out(fo), .block_busy(busy), .bus(bus), .rdata(rdata));
    bcw_partner bcw_partner_inst (.mclk(mclk), .arst_n(arst_n), .go(go), .word(word),
        .stall(stall), .cw0_ready(cwr), .lane_ready(lr), .control_word_bus(cwb),
        .cw0_valid(cwv), .lane_valid(lv), .lane_data(ld));
    // ****
    // Helpers
    // ****
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic ok(input logic [CW_W-1:0] w);
        return w[7:0] == IDX_OK && w[34:32] <= OP_SET && (w[34:32] != OP_LOAD
            || (w[24:16] >= ROWS_MIN && w[24:16] <= ROWS_PER_BLOCK));
    endfunction
    function automatic bcw_fields_t exp_f(input logic [CW_W-1:0] w);
        bcw_fields_t f;
        f.block = w[11:8];
        f.op = w[34:32];
        f.single = w[30];
        f.segment = w[30] ? w[29:28] : 2'h0;
        f.rows = w[34:32] == OP_LOAD ? w[24:16] : ROWS_PER_BLOCK;
        f.reverse = w[34:32] == OP_LOAD ? w[36] : 1'b0;
        return f;
    endfunction
    // Reserved bits stay random to show they are ignored
    function automatic logic [CW_W-1:0] mk(input logic [31:0] r, input logic [7:0] i,
        input logic [2:0] op, input logic [8:0] rows, input logic rev);
        logic [CW_W-1:0] w;
        w = {6{r}};
        w[7:0] = i;
        w[34:32] = op;
        w[24:16] = rows;
        w[36] = rev;
        return w;
    endfunction
    task automatic cmp(input logic [255:0] got, input logic [255:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (failures == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
        bus <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge mclk);
        bus <= '0;
        @(negedge mclk);
        cmp(rdata, e);
    endtask
    // Random stalls and side channel traffic every cycle
    always @(posedge mclk)
    begin
        sreg <= xs(sreg);
        stall <= sreg[0] & sreg[1];
        ov <= sreg[4:2];
    end
    task automatic run(input logic [CW_W-1:0] w);
        int n;
        int k;
        bcw_fields_t f;
        f = exp_f(w);
        @(posedge mclk);
        word <= w;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        for (k = 0; k < 50; k++)
        begin
            @(negedge mclk);
            if (cwv === 1'b1 && cwr === 1'b1)
                break;
        end
        if (k == 50)
        begin
            failures++;
            print_verdict();
        end
        @(negedge mclk);
        if (!ok(w))
        begin
            n_dis++;
            cmp(busy, 1'b0);
            cmp(fo, last_f);
            return;
        end
        n_acc++;
        last_f = f;
        cmp(fo, f);
        n = 0;
        for (k = 0; k < 400; k++)
        begin
            if (row.we === 1'b1)
            begin
                cmp(row.addr, f.reverse ? ROW_LAST - n : ROW_FIRST + n);
                if (f.op != OP_LOAD)
                    cmp(row.data, {256{f.op == OP_SET}});
                n++;
            end
            if (busy !== 1'b1)
                break;
            @(negedge mclk);
        end
        cmp(n, f.op == OP_LOAD ? f.rows : 136);
        if (k == 400)
        begin
            failures++;
            print_verdict();
        end
    endtask
    // ****
    // Main sequence
    // ****
    initial
    begin
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        rd(REG_CTRL, 32'h1);
        cmp({ordy, lr}, 7'h70);
        run(mk(seed, 8'h00, OP_LOAD, 9'h001, 1'b0));
        run(mk(seed, 8'h00, OP_LOAD, 9'h088, 1'b1));
        run(mk(seed, 8'h00, OP_LOAD, 9'h089, 1'b0));
        run(mk(seed, 8'h00, OP_LOAD, 9'h000, 1'b1));
        run(mk(seed, 8'h80, OP_CLEAR, 9'h000, 1'b1));
        for (int j = 0; j < 8; j++)
            run(mk(xs(seed + j), 8'h00, j[2:0], 9'h0c8, 1'b1));
        for (int j = 0; j < 30; j++)
        begin
            seed = xs(seed);
            run(mk(seed, seed[31:28] == 4'h0 ? seed[27:20] : 8'h00,
                seed[16] ? seed[19:17] : OP_LOAD, seed[8:0] % 140, seed[12]));
        end
        wr(REG_CTRL, 32'h0);
        @(negedge mclk);
        cmp(cwr, 1'b0);
        rd(REG_CTRL, 32'h0);
        wr(REG_CTRL, 32'h1);
        // Abort a set block part way; a full clear then leaves known state
        @(posedge mclk);
        word <= mk(seed, 8'h00, OP_SET, 9'h000, 1'b0);
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        repeat (4) @(posedge mclk);
        wr(REG_CTRL, 32'h3);
        @(negedge mclk);
        cmp(busy, 1'b0);
        n_acc++;
        run(mk(seed, 8'h00, OP_CLEAR, 9'h000, 1'b1));
        rd(REG_STATUS, {13'h0, 9'h000, ROW_LAST + 8'h01, 2'h0});
        rd(REG_FIELDS, {12'h0, last_f});
        rd(REG_ACCEPT, n_acc);
        rd(REG_DISCARD, n_dis);
        wr(REG_DISCARD, 32'h0);
        rd(REG_DISCARD, 32'h0);
        rd(8'h20, 32'h0);
        print_verdict();
    end
endmodule
